// file: dpr_regbank.sv
/*
 * volatile register bank of a one- or two-channel digital potentiometer:
 * wiper values, terminal control and shutdown status, with network outputs.
 * assumes a serial command decoder on mclk_i that presents one request per
 * access and pulses cmd_done_i when the frame ends; supply_ok_i and
 * hw_poweroff_input_n_i are asynchronous levels from pins/analog.
 */
`timescale 1ns/1ps
module dpr_regbank
    import dpr_pkg::*;
#(
    parameter int         NUM_NETS  = 2,
    parameter int         WIPER_BITS = 8
) (
    input  wire logic              mclk_i,
    input  wire logic              rstn_i,
    input  wire logic              supply_ok_i,
    input  wire logic              hw_poweroff_input_n_i,
    input  wire dpr_pkg::dpr_req_t req_i,
    input  wire logic              cmd_done_i,
    output logic [8:0]             rdata_o,
    output logic                   rvalid_o,
    output logic                   serial_en_o,
    output logic [8:0]             wiper0_o,
    output logic [8:0]             wiper1_o,
    output dpr_pkg::dpr_term_t     net0_term_o,
    output dpr_pkg::dpr_term_t     net1_term_o,
    output logic                   hw_off_o
);
    import dpr_pkg::*;

    // =======================================================
    // constants
    localparam logic [8:0] WIPER_DEFAULT = (WIPER_BITS == 8) ? WIPER_MID_8BIT : WIPER_MID_7BIT;
    localparam logic       HAS_NET1      = (NUM_NETS > 1);

    function automatic logic loc_exists(input logic [3:0] a);
        loc_exists = (a == LOC_WIPER0) || (a == LOC_CTRL) || (a == LOC_STATUS)
                   || (HAS_NET1 && (a == LOC_WIPER1));
    endfunction : loc_exists

    // =======================================================
    // synchronised pin levels
    logic supply_ok_s;
    logic poweroff_n_s;

    dpr_sync #(.RESET_VAL(1'b0)) u_sync_supply (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    (supply_ok_i),
        .q_o    (supply_ok_s)
    );

    dpr_sync #(.RESET_VAL(1'b1)) u_sync_down (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .d_i    (hw_poweroff_input_n_i),
        .q_o    (poweroff_n_s)
    );

    // =======================================================
    // registers
    logic [8:0] wiper0_q, wiper0_d;
    logic [8:0] wiper1_q, wiper1_d;
    logic [7:0] ctrl_q, ctrl_d;       // stored control bits
    logic [7:0] ctrl_app_q, ctrl_app_d; // copy driving the terminals
    logic       ctrl_pend_q, ctrl_pend_d;
    logic [8:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;
    logic       brownout_q, brownout_d;
    logic       hw_off;
    logic       access;

    assign hw_off = !poweroff_n_s;
    // requests are ignored entirely below trip; shutdown does not block them
    assign access = req_i.valid && supply_ok_s;

    function automatic logic [8:0] read_loc(input logic [3:0] a,
                                            input logic [8:0] w0,
                                            input logic [8:0] w1,
                                            input logic [7:0] tc,
                                            input logic       off);
        read_loc = RESERVED_READ;
        if (a == LOC_WIPER0)
            read_loc = w0;
        else if (a == LOC_WIPER1 && HAS_NET1)
            read_loc = w1;
        else if (a == LOC_CTRL)
            read_loc = {1'b1, tc};
        else if (a == LOC_STATUS) begin
            read_loc = STATUS_BASE;
            read_loc[ST_OFF_BIT] = off;
        end
    endfunction : read_loc

    always_comb begin
        wiper0_d    = wiper0_q;
        wiper1_d    = wiper1_q;
        ctrl_d      = ctrl_q;
        ctrl_app_d  = ctrl_app_q;
        ctrl_pend_d = ctrl_pend_q;
        rdata_d     = rdata_q;
        rvalid_d    = 1'b0;
        brownout_d  = brownout_q;
        if (!supply_ok_s) begin
            // below trip: interface dead, state reloaded on recovery
            brownout_d  = 1'b1;
            ctrl_pend_d = 1'b0;
        end else if (brownout_q) begin
            // recovery from brown-out: load defaults as at power-on
            brownout_d  = 1'b0;
            wiper0_d    = WIPER_DEFAULT;
            wiper1_d    = WIPER_DEFAULT;
            ctrl_d      = CTRL_RESET[7:0];
            ctrl_app_d  = CTRL_RESET[7:0];
        end else begin
            if (access && req_i.write && loc_exists(req_i.addr)) begin
                if (req_i.addr == LOC_WIPER0)
                    wiper0_d = req_i.wdata;
                else if (req_i.addr == LOC_WIPER1)
                    wiper1_d = req_i.wdata;
                else if (req_i.addr == LOC_CTRL) begin
                    ctrl_d      = req_i.wdata[7:0];
                    ctrl_pend_d = 1'b1;
                end
            end
            if (access && !req_i.write) begin
                rdata_d  = read_loc(req_i.addr, wiper0_q, wiper1_q, ctrl_q, hw_off);
                rvalid_d = 1'b1;
            end
            // terminals follow only once the writing frame has ended
            if (cmd_done_i && (ctrl_pend_q || ctrl_pend_d)) begin
                ctrl_app_d  = ctrl_d;
                ctrl_pend_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wiper0_q    <= WIPER_DEFAULT;
            wiper1_q    <= WIPER_DEFAULT;
            ctrl_q      <= CTRL_RESET[7:0];
            ctrl_app_q  <= CTRL_RESET[7:0];
            ctrl_pend_q <= 1'b0;
            rdata_q     <= RESERVED_READ;
            rvalid_q    <= 1'b0;
            brownout_q  <= 1'b1;
        end else begin
            wiper0_q    <= wiper0_d;
            wiper1_q    <= wiper1_d;
            ctrl_q      <= ctrl_d;
            ctrl_app_q  <= ctrl_app_d;
            ctrl_pend_q <= ctrl_pend_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= rvalid_d;
            brownout_q  <= brownout_d;
        end
    end

    // =======================================================
    // network terminal mapping
    dpr_pkg::dpr_term_t net1_raw;

    dpr_term_map u_map0 (
        .nibble_i (ctrl_app_q[TC_NET0_LSB +: 4]),
        .hw_off_i (hw_off),
        .term_o   (net0_term_o)
    );

    dpr_term_map u_map1 (
        .nibble_i (ctrl_app_q[TC_NET1_LSB +: 4]),
        .hw_off_i (hw_off),
        .term_o   (net1_raw)
    );

    // absent second network left fully disconnected
    assign net1_term_o = HAS_NET1 ? net1_raw : '0;
    assign rdata_o     = rdata_q;
    assign rvalid_o    = rvalid_q;
    assign serial_en_o = supply_ok_s && !brownout_q;
    assign wiper0_o    = wiper0_q;
    assign wiper1_o    = HAS_NET1 ? wiper1_q : RESERVED_READ;
    assign hw_off_o    = hw_off;
endmodule : dpr_regbank

// file: dpr_pkg.sv
/*
 * package for the digital potentiometer volatile register bank: location map,
 * field positions, reset values and the carrier structs.
 * assumes a single 40 mhz clock and a serial front end outside this block.
 */
// Summary of operation
// - sixteen locations of nine bits, selected by a four-bit index.
// - 00h wiper zero, 01h wiper one, 04h terminal control, 05h status.
// - second wiper exists only when two channels are configured.
// - on reset release wipers and terminal control take their defaults.
// - terminal control resets to 1FFh, all terminals connected.
// - below trip voltage the serial side is disabled and ignored.
// - between trip and minimum supply, commands still execute normally.
// - status is read-only; writes to it do nothing.
// - status bits 8 to 5 read one; bits 4,3,2,0 reserved.
// - status bit 1 reads one while the shutdown input is low.
// - serial access keeps working during hardware shutdown.
// - shutdown disconnects terminal a and ties wiper to terminal b.
// - new terminal control value reaches terminals only at command completion.
// - control bit 8 reads one; bits 7-4 network one, 3-0 network zero.
// - force-off bit at zero applies the shutdown configuration to that network.
// - each connect bit connects its terminal at one, disconnects at zero.
// - shutdown input overrides connect bits without changing stored values.
// - terminal control never changes the wiper values.
// - wiper default is mid-scale: 80h eight-bit, 40h seven-bit.
package dpr_pkg;
    // =======================================================
    // location map
    localparam logic [3:0] LOC_WIPER0 = 4'h0;
    localparam logic [3:0] LOC_WIPER1 = 4'h1;
    localparam logic [3:0] LOC_CTRL   = 4'h4;
    localparam logic [3:0] LOC_STATUS = 4'h5;

    // =======================================================
    // field positions and values
    localparam int         TC_FIXED_BIT   = 8;
    localparam int         TC_NET1_LSB    = 4;
    localparam int         TC_NET0_LSB    = 0;
    localparam int         TC_FORCE_OFS   = 3;
    localparam int         TC_A_OFS       = 2;
    localparam int         TC_W_OFS       = 1;
    localparam int         TC_B_OFS       = 0;
    localparam int         ST_OFF_BIT     = 1;
    localparam logic [8:0] CTRL_RESET     = 9'h1FF;
    localparam logic [8:0] STATUS_BASE    = 9'h1E0;
    localparam logic [8:0] RESERVED_READ  = 9'h000;
    localparam logic [8:0] WIPER_MID_8BIT = 9'h080;
    localparam logic [8:0] WIPER_MID_7BIT = 9'h040;

    // =======================================================
    // carriers
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [3:0] addr;
        logic [8:0] wdata;
    } dpr_req_t;

    typedef struct packed {
        logic a_conn;
        logic w_conn;
        logic b_conn;
        logic w_to_b;
    } dpr_term_t;
endpackage : dpr_pkg

// file: dpr_sync.sv
/*
 * two-flop synchroniser for one asynchronous level.
 * assumes the input toggles slower than the clock.
 */
`timescale 1ns/1ps
module dpr_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    // =======================================================
    // first flop feeds only the second
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = d_i;
        sync_d = meta_q;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q_o = sync_q;
endmodule : dpr_sync

// file: dpr_term_map.sv
/*
 * terminal configuration of one resistor network from its control nibble
 * and the synchronised shutdown state.
 * assumes the nibble is the applied copy, not the pending write.
 */
`timescale 1ns/1ps
module dpr_term_map
    import dpr_pkg::*;
(
    input  wire logic [3:0] nibble_i,
    input  wire logic       hw_off_i,
    output dpr_pkg::dpr_term_t term_o
);
    import dpr_pkg::*;

    // =======================================================
    // override: stored bits untouched, merely ignored while forced
    logic forced;

    always_comb begin
        forced = hw_off_i || !nibble_i[TC_FORCE_OFS];
        if (forced) begin
            term_o.a_conn = 1'b0;
            term_o.w_conn = 1'b1;
            term_o.b_conn = 1'b1;
            term_o.w_to_b = 1'b1;
        end else begin
            term_o.a_conn = nibble_i[TC_A_OFS];
            term_o.w_conn = nibble_i[TC_W_OFS];
            term_o.b_conn = nibble_i[TC_B_OFS];
            term_o.w_to_b = 1'b0;
        end
    end
endmodule : dpr_term_map

// file: dpr_regbank_properties.sv
/* port checker for the register bank.
   assumes one clock domain and the two-channel build. */
`timescale 1ns/1ps
module dpr_regbank_properties
    import dpr_pkg::*;
#(
    parameter int NUM_NETS   = 2,
    parameter int WIPER_BITS = 8
) (
    input wire logic               mclk_i,
    input wire logic               rstn_i,
    input wire logic               supply_ok_i,
    input wire logic               hw_poweroff_input_n_i,
    input wire dpr_pkg::dpr_req_t  req_i,
    input wire logic               cmd_done_i,
    input wire logic [8:0]         rdata_o,
    input wire logic               rvalid_o,
    input wire logic               serial_en_o,
    input wire logic [8:0]         wiper0_o,
    input wire logic [8:0]         wiper1_o,
    input wire dpr_pkg::dpr_term_t net0_term_o,
    input wire dpr_pkg::dpr_term_t net1_term_o,
    input wire logic               hw_off_o
);
    // ============================================================
    // properties
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic rd_ok;
    logic wr_ok;
    assign rd_ok = req_i.valid && !req_i.write && serial_en_o;
    assign wr_ok = req_i.valid && req_i.write;
    a_read_answer: assert property (rd_ok |=> rvalid_o)
        else $error("read not answered");
    a_no_stray: assert property (rvalid_o |-> $past(rd_ok))
        else $error("read data without a request");
    a_status_word: assert property (rd_ok && req_i.addr == LOC_STATUS |=>
        rdata_o[8:5] == 4'hF && rdata_o[1] == $past(hw_off_o)) else $error("status word wrong");
    a_ctrl_fixed: assert property (rd_ok && req_i.addr == LOC_CTRL |=> rdata_o[8])
        else $error("control bit 8 not one");
    a_rsv_read: assert property (rd_ok && req_i.addr inside {4'h2, 4'h3, [4'h6:4'hF]}
        |=> rdata_o == RESERVED_READ) else $error("reserved read not constant");
    a_serial_off: assert property (!supply_ok_i [*3] |-> !serial_en_o)
        else $error("serial side open below trip");
    a_off_sync: assert property (!hw_poweroff_input_n_i [*3] |-> hw_off_o)
        else $error("shutdown not seen after sync");
    a_off_terms: assert property (hw_off_o |-> net0_term_o == 4'h7 && net1_term_o == 4'h7)
        else $error("shutdown configuration wrong");
    a_term_hold: assert property (serial_en_o && $past(serial_en_o) && !$past(cmd_done_i)
        && $stable(hw_off_o) |-> $stable(net0_term_o) && $stable(net1_term_o)) else $error("terms moved early");
    a_wiper_keep: assert property ($past(serial_en_o) && !$past(wr_ok)
        |-> $stable(wiper0_o) && $stable(wiper1_o)) else $error("wiper moved without write");
endmodule : dpr_regbank_properties

// file: dpr_host_model.sv
/* host side command source for the register bank.
   assumes requests launch on the falling edge of mclk_i. */
`timescale 1ns/1ps
module dpr_host_model
    import dpr_pkg::*;
(
    input  wire logic         mclk_i,
    output dpr_pkg::dpr_req_t req_o,
    output logic              done_o
);
    // ============================================================
    // bus cycles
    initial begin
        req_o = '0;
        done_o = 1'b0;
    end
    // released fields show the inverse, so a stale value is never read
    task automatic access(input logic wr, input logic [3:0] a, input logic [8:0] d);
        @(negedge mclk_i);
        req_o = '{valid: 1'b1, write: wr, addr: a, wdata: d};
        @(negedge mclk_i);
        req_o = '{valid: 1'b0, write: ~wr, addr: ~a, wdata: ~d};
    endtask : access
    // frame end; a supply drop before it discards a pending control write
    task automatic finish_frame();
        @(negedge mclk_i);
        done_o = 1'b1;
        @(negedge mclk_i);
        done_o = 1'b0;
    endtask : finish_frame
endmodule : dpr_host_model

// file: dpr_regbank_tb.sv
/* self-checking bench for the register bank with a host model.
   assumes 40 mhz clock and the two-channel eight-bit build. */
`timescale 1ns/1ps
module dpr_regbank_tb;
    import dpr_pkg::*;
    logic       mclk_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       supply = 1'b1;
    logic       hw_n   = 1'b1;
    dpr_req_t   req;
    logic       done, rvalid, sen, hw_off;
    logic [8:0] rdata, wp0, wp1;
    dpr_term_t  t0, t1;
    logic [8:0] expq[$];
    int         miscompares = 0;
    int         n_tests = 0;
    logic [7:0] tc, ap, wv;
    initial forever #12.5 mclk_i = ~mclk_i;
    dpr_host_model host (.mclk_i(mclk_i), .req_o(req), .done_o(done));
    dpr_regbank #(.NUM_NETS(2), .WIPER_BITS(8)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .supply_ok_i(supply), .hw_poweroff_input_n_i(hw_n), .req_i(req), .cmd_done_i(done),
        .rdata_o(rdata), .rvalid_o(rvalid), .serial_en_o(sen), .wiper0_o(wp0), .wiper1_o(wp1),
        .net0_term_o(t0), .net1_term_o(t1), .hw_off_o(hw_off));
    // ============================================================
    // helpers
    task automatic cmp9(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp9
    task automatic cmp_t(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp_t
    function automatic logic [3:0] term_of(input logic [3:0] n);
        return !n[3] ? 4'h7 : {n[2:0], 1'b0};
    endfunction : term_of
    task automatic rd(input logic [3:0] a, input logic [8:0] e);
        expq.push_back(e);
        host.access(1'b0, a, 9'h000);
    endtask : rd
    task automatic ticks(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : ticks
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    task automatic wait_en();
        for (int k = 0; k < 50 && sen !== 1'b1; k++) @(negedge mclk_i);
        if (sen !== 1'b1) begin
            miscompares++;
            close_out();
        end
    endtask : wait_en
    // read data is checked against the oldest note
    always @(negedge mclk_i) begin
        if (rvalid === 1'b1) begin
            if (expq.size() == 0) cmp9("unexpected rdata", 9'h1FF ^ rdata, rdata);
            else cmp9("rdata", expq.pop_front(), rdata);
        end
    end
    // ============================================================
    // scenarios
    initial begin
        void'($urandom(32'h499B));
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        rstn_i = 1'b1;
        wait_en();
        rd(LOC_WIPER0, WIPER_MID_8BIT);
        rd(LOC_WIPER1, WIPER_MID_8BIT);
        rd(LOC_CTRL, CTRL_RESET);
        rd(LOC_STATUS, STATUS_BASE);
        cmp_t("net0", 4'hE, t0);
        $display("defaults test done");
        wv = 8'($urandom);
        host.access(1'b1, LOC_WIPER0, {1'b0, wv});
        host.access(1'b1, LOC_WIPER1, {1'b0, ~wv});
        host.access(1'b1, 4'h3, 9'h155);
        host.access(1'b1, LOC_STATUS, 9'h000);
        rd(LOC_WIPER0, {1'b0, wv});
        rd(LOC_WIPER1, {1'b0, ~wv});
        rd(4'h3, RESERVED_READ);
        rd(4'hF, RESERVED_READ);
        rd(LOC_STATUS, STATUS_BASE);
        cmp9("wiper0 out", {1'b0, wv}, wp0);
        cmp9("wiper1 out", {1'b0, ~wv}, wp1);
        $display("map test done");
        ap = 8'hFF;
        for (int i = 0; i < 2; i++) begin
            tc = 8'($urandom);
            tc[3] = i[0];
            tc[7] = ~i[0];
            host.access(1'b1, LOC_CTRL, {1'b0, tc});
            ticks(2);
            cmp_t("net0 pending", term_of(ap[3:0]), t0);
            cmp_t("net1 pending", term_of(ap[7:4]), t1);
            host.finish_frame();
            ticks(2);
            ap = tc;
            cmp_t("net0", term_of(tc[3:0]), t0);
            cmp_t("net1", term_of(tc[7:4]), t1);
            rd(LOC_CTRL, {1'b1, tc});
            rd(LOC_WIPER0, {1'b0, wv});
        end
        $display("terminal control test done");
        hw_n = 1'b0;
        ticks(4);
        cmp_t("net0 off", 4'h7, t0);
        cmp_t("net1 off", 4'h7, t1);
        cmp_t("shutdown flag", 4'h1, {3'b000, hw_off});
        rd(LOC_STATUS, STATUS_BASE | 9'h002);
        rd(LOC_CTRL, {1'b1, ap});
        hw_n = 1'b1;
        ticks(4);
        cmp_t("shutdown flag", 4'h0, {3'b000, hw_off});
        cmp_t("net0 back", term_of(ap[3:0]), t0);
        rd(LOC_STATUS, STATUS_BASE);
        $display("shutdown test done");
        ticks(2);
        supply = 1'b0;
        ticks(4);
        cmp_t("serial enable", 4'h0, {3'b000, sen});
        host.access(1'b1, LOC_WIPER0, {1'b0, ~wv});
        host.access(1'b0, LOC_WIPER0, 9'h000);
        cmp9("wiper0 while off", {1'b0, wv}, wp0);
        supply = 1'b1;
        wait_en();
        rd(LOC_WIPER0, WIPER_MID_8BIT);
        rd(LOC_CTRL, CTRL_RESET);
        cmp_t("net0 reload", 4'hE, t0);
        cmp_t("net1 reload", 4'hE, t1);
        host.access(1'b1, LOC_CTRL, {1'b0, ap});
        host.finish_frame();
        ticks(3);
        cmp_t("net0 rewrite", term_of(ap[3:0]), t0);
        cmp_t("net1 rewrite", term_of(ap[7:4]), t1);
        $display("brown-out test done");
        close_out();
    end
endmodule : dpr_regbank_tb

bind dpr_regbank dpr_regbank_properties #(.NUM_NETS(NUM_NETS), .WIPER_BITS(WIPER_BITS)) u_props (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .supply_ok_i(supply_ok_i), .hw_poweroff_input_n_i(hw_poweroff_input_n_i),
    .req_i(req_i), .cmd_done_i(cmd_done_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .serial_en_o(serial_en_o),
    .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .net0_term_o(net0_term_o), .net1_term_o(net1_term_o),
    .hw_off_o(hw_off_o));
